// ---- common/dcf_pkg.sv ----
// shared constants and pin bundle types for the dual-clock fifo with mailboxes
package dcf_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int DATA_W = 36;
   localparam int DEPTH = 512;
   localparam int AW = 9;
   localparam int PW = AW + 1;
   localparam int STAGE_DEPTH = 16;
   localparam logic [PW-1:0] DEPTH_COUNT = 10'h200;
   localparam logic [PW-1:0] PTR_ONE = 10'h001;

   // ----------------------------------------
   // offset registers
   // ----------------------------------------
   localparam logic [AW-1:0] X_RESET = 9'h008;
   localparam logic [AW-1:0] Y_RESET = 9'h008;
   localparam int PAR_X_LSB = 0;
   localparam int PAR_Y_LSB = 16;

   // ----------------------------------------
   // sampled pin bundles
   // ----------------------------------------
   typedef struct packed {
      logic clk;
      logic cs_n;
      logic en;
      logic wsel;
      logic mb;
      logic par_load;
      logic ser_en_n;
      logic ser_data;
      logic [DATA_W-1:0] data;
   } dcf_pa_s;

   typedef struct packed {
      logic clk;
      logic cs_n;
      logic en;
      logic wsel;
      logic mb;
      logic rtm;
      logic rfm;
      logic [DATA_W-1:0] data;
   } dcf_pb_s;

endpackage

// ---- dv/dcf_fifo_checker.sv ----
// concurrent checks on the fifo top-level pins
module dcf_fifo_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic read_port_clock,
   // port one
   input wire logic write_port_select_n,
   input wire logic side_one_write_select,
   input wire logic side_one_mailbox_select,
   input wire logic side_one_data_oe_n,
   input wire logic input_ready_flag,
   input wire logic almost_full_n,
   input wire logic mail_to_one_flag_n,
   // port two
   input wire logic read_port_select_n,
   input wire logic side_two_write_select,
   input wire logic side_two_mailbox_select,
   input wire logic side_two_data_oe_n,
   input wire logic output_ready_flag,
   input wire logic almost_empty_n,
   input wire logic mail_to_two_flag_n
);
   import dcf_pkg::*;
   // one domain; pins lag by the edge finder, so causes sit three clocks back
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   chk_one_bus_off: assert property ((write_port_select_n || side_one_write_select) [*6] |-> side_one_data_oe_n)
      else $error("port one bus driven while released");
   chk_two_bus_off: assert property ((read_port_select_n || !side_two_write_select) [*6] |-> side_two_data_oe_n)
      else $error("port two bus driven while released");
   chk_full_implies_af: assert property ($fell(input_ready_flag) |-> !almost_full_n)
      else $error("full without almost full");
   chk_ae_needs_word: assert property ($rose(almost_empty_n) |-> output_ready_flag)
      else $error("almost empty released with no word ready");
   chk_or_on_edge: assert property ($changed(output_ready_flag) |-> $past(read_port_clock, 3))
      else $error("output ready moved off a port two edge");
   chk_mail_two_set: assert property ($fell(mail_to_two_flag_n) |->
      $past(side_one_mailbox_select, 3) && $past(side_one_write_select, 3) && !$past(write_port_select_n, 3))
      else $error("mail flag two set without a mailbox write");
   chk_mail_two_clr: assert property ($rose(mail_to_two_flag_n) |->
      $past(side_two_mailbox_select, 3) && $past(side_two_write_select, 3))
      else $error("mail flag two cleared without a mailbox read");
   chk_mail_one_set: assert property ($fell(mail_to_one_flag_n) |->
      $past(side_two_mailbox_select, 3) && !$past(side_two_write_select, 3))
      else $error("mail flag one set without a mailbox write");
endmodule // dcf_fifo_checker

bind dcf_fifo_mailbox dcf_fifo_checker chk_i (.clk, .rst_b, .read_port_clock, .write_port_select_n,
   .side_one_write_select, .side_one_mailbox_select, .side_one_data_oe_n, .input_ready_flag, .almost_full_n,
   .mail_to_one_flag_n, .read_port_select_n, .side_two_write_select, .side_two_mailbox_select,
   .side_two_data_oe_n, .output_ready_flag, .almost_empty_n, .mail_to_two_flag_n);

// ---- dv/dcf_port_model.sv ----
// far-side controller model: free-running port clock and bus driver
module dcf_port_model #(
   parameter int PH = 3
) (
   // system clock
   input wire logic clk,
   // bus parties
   input wire logic drv_en,
   input wire logic [dcf_pkg::DATA_W-1:0] drv_val,
   input wire logic oe_n,
   input wire logic [dcf_pkg::DATA_W-1:0] dout,
   // pins toward the device
   output logic pclk,
   output logic [dcf_pkg::DATA_W-1:0] bus
);
   timeunit 1ns;
   timeprecision 100ps;
   import dcf_pkg::*;
   logic [DATA_W-1:0] last = '0;
   // port clock runs free at 64 ns, phase unrelated to clk
   initial
   begin
      pclk = 1'b0;
      #(PH);
      forever #32 pclk = ~pclk;
   end
   // undriven bus flips every cycle so a stale word never passes as read data
   always @(posedge clk) last <= bus;
   assign bus = !oe_n ? dout : drv_en ? drv_val : ~last;
endmodule // dcf_port_model

// ---- dv/tb_top.sv ----
// self-checking bench for the dual-clock fifo with mailboxes
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dcf_pkg::*;
   localparam logic [DATA_W-1:0] W0 = 36'h5_A5C3_0000;
   localparam logic [DATA_W-1:0] M1 = 36'hC_0FFE_E001;
   localparam logic [DATA_W-1:0] M2 = 36'h3_1234_5678;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] cs_n = 2'h3;
   logic [1:0] en = 2'h0;
   logic [1:0] ws = 2'h0;
   logic [1:0] mb = 2'h0;
   logic [1:0] den = 2'h0;
   logic rtm = 1'b0;
   logic rfm = 1'b0;
   logic [DATA_W-1:0] drv [2] = '{default: '0};
   wire [1:0] pclk;
   wire [1:0] oe_n;
   wire [DATA_W-1:0] dout [2];
   wire [DATA_W-1:0] bus [2];
   wire ir, af_n, mb1_n, or_f, ae_n, mb2_n;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;
   logic [DATA_W-1:0] q;

   always #4 clk = ~clk;

   dcf_port_model #(.PH(3)) pa (.clk(clk), .drv_en(den[0]), .drv_val(drv[0]), .oe_n(oe_n[0]), .dout(dout[0]),
      .pclk(pclk[0]), .bus(bus[0]));
   dcf_port_model #(.PH(21)) pb (.clk(clk), .drv_en(den[1]), .drv_val(drv[1]), .oe_n(oe_n[1]), .dout(dout[1]),
      .pclk(pclk[1]), .bus(bus[1]));
   dcf_fifo_mailbox dut (.clk(clk), .rst_b(rst_b), .write_port_clock(pclk[0]), .write_port_select_n(cs_n[0]),
      .write_port_enable(en[0]), .side_one_write_select(ws[0]), .side_one_mailbox_select(mb[0]),
      .offset_parallel_load(1'b0), .offset_serial_enable_n(1'b1), .offset_serial_data(1'b0),
      .side_one_data_in(bus[0]), .side_one_data_out(dout[0]), .side_one_data_oe_n(oe_n[0]),
      .input_ready_flag(ir), .almost_full_n(af_n), .mail_to_one_flag_n(mb1_n), .read_port_clock(pclk[1]),
      .read_port_select_n(cs_n[1]), .read_port_enable(en[1]), .side_two_write_select(ws[1]),
      .side_two_mailbox_select(mb[1]), .retransmit_mode(rtm), .read_from_mark(rfm),
      .side_two_data_in(bus[1]), .side_two_data_out(dout[1]), .side_two_data_oe_n(oe_n[1]),
      .output_ready_flag(or_f), .almost_empty_n(ae_n), .mail_to_two_flag_n(mb2_n));

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // one access on port p, set up after a port fall and held well past the rise
   task automatic op(input int p, input logic c, input logic e, input logic w, input logic m, input logic [35:0] d);
      wait (pclk[p] === 1'b1);
      wait (pclk[p] === 1'b0);
      @(posedge clk);
      cs_n[p] <= c;
      en[p] <= e;
      ws[p] <= w;
      mb[p] <= m;
      drv[p] <= d;
      den[p] <= !c && (w ^ p[0]);
      wait (pclk[p] === 1'b1);
      repeat (4) @(posedge clk);
      @(negedge clk);
      q = bus[p];
      @(posedge clk);
      cs_n[p] <= 1'b1;
      en[p] <= 1'b0;
      den[p] <= 1'b0;
      @(negedge clk);
   endtask

   // look at the waiting word with enable low, then take it
   task automatic pop(input logic [DATA_W-1:0] exp);
      op(1, 1'b0, 1'b0, 1'b1, 1'b0, '0);
      check(q, exp);
      op(1, 1'b0, 1'b1, 1'b1, 1'b0, '0);
   endtask

   // hang guard: a full fill and drain needs under 30000 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         n_fail++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      check({ir, af_n, mb1_n, oe_n[0], or_f, ae_n, mb2_n, oe_n[1]}, 8'h73);
      rst_b <= 1'b1;
      repeat (24) @(posedge clk);
      check(ir, 1'b1);
      op(0, 1'b1, 1'b1, 1'b1, 1'b1, M1);
      op(0, 1'b0, 1'b0, 1'b1, 1'b1, M1);
      check(mb2_n, 1'b1);
      op(0, 1'b0, 1'b1, 1'b1, 1'b1, M1);
      check(mb2_n, 1'b0);
      op(1, 1'b0, 1'b1, 1'b1, 1'b1, '0);
      check(q, M1);
      check(mb2_n, 1'b1);
      op(1, 1'b0, 1'b1, 1'b0, 1'b1, M2);
      check(mb1_n, 1'b0);
      op(0, 1'b0, 1'b1, 1'b0, 1'b1, '0);
      check(q, M2);
      check(mb1_n, 1'b1);
      // junk words between the good ones must never reach port two
      op(0, 1'b0, 1'b1, 1'b1, 1'b0, W0);
      op(0, 1'b1, 1'b1, 1'b1, 1'b0, ~W0);
      op(0, 1'b0, 1'b0, 1'b1, 1'b0, ~W0);
      op(0, 1'b0, 1'b1, 1'b1, 1'b0, W0 + 1);
      repeat (4) op(1, 1'b1, 1'b0, 1'b1, 1'b0, '0);
      check({or_f, ae_n}, 2'h2);
      op(1, 1'b1, 1'b1, 1'b1, 1'b0, '0);
      pop(W0);
      pop(W0 + 1);
      op(1, 1'b0, 1'b1, 1'b1, 1'b0, '0);
      check(or_f, 1'b0);
      // fill with port two stalled until writes are refused
      n = 0;
      while (ir === 1'b1 && n < DEPTH + STAGE_DEPTH + 4)
      begin
         op(0, 1'b0, 1'b1, 1'b1, 1'b0, W0 + n);
         n++;
      end
      op(0, 1'b0, 1'b1, 1'b1, 1'b0, ~W0);
      check({ir, af_n, ae_n}, 3'h1);
      // drain: words come back in order, dropped writes never appear
      n = 0;
      while (or_f === 1'b1 && n < DEPTH + STAGE_DEPTH + 4)
      begin
         pop(W0 + n);
         n++;
      end
      check(n >= DEPTH && n <= DEPTH + STAGE_DEPTH, 1'b1);
      check({ir, af_n, ae_n, or_f}, 4'hC);
      wrap_up();
   end
endmodule // tb_top

// ---- rtl/dcf_fifo_mailbox.sv ----
// dual-port fifo with mailboxes, retransmit and programmable flags
//
// Behaviour
// - 36-bit fifo array, port one to two
// - transfers only on qualified rising port edges
// - port clocks treated independent, any phase relation
// - writes on port-one edges, reads on port-two edges
// - input ready, almost full: two port-one stages
// - output ready, almost empty: two port-two stages
// - almost empty low when words at/below X
// - almost full low when free at/below Y
// - separate empty and full ready flags
// - port one access needs select low
// - port one bus released while select high
// - port two access needs select low
// - port two bus released while select high
// - port one enable high qualifies the edge
// - port two enable high qualifies the edge
// - both data buses bidirectional, 36 bits
// - two mailboxes, one per direction
// - each mailbox flags unread new mail
// - retransmit replays words already read
// - offsets loaded from port one or serially
// - port one select high writes, low reads
// - port two select low writes, high reads
// - input ready low means full, writes ignored
// - output ready rises third port-two edge

// ----------------------------------------
// elastic stage in front of the array
// ----------------------------------------
module dcf_stage_fifo #(
   parameter int W = 36,
   parameter int D = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int SAW = $clog2(D);

   typedef struct packed {
      logic [SAW-1:0] wp;
      logic [SAW-1:0] rp;
      logic [SAW:0] cnt;
   } dcf_sf_s;

   dcf_sf_s st_reg;
   dcf_sf_s st_next;
   logic [W-1:0] mem [D];
   logic push;
   logic pop;

   // honest flags straight from the count
   assign in_ready = (st_reg.cnt != (SAW+1)'(D));
   assign out_valid = (st_reg.cnt != '0);
   assign out_data = mem[st_reg.rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // pointer and count update
   always_comb
   begin
      st_next = st_reg;
      if (push)
      begin
         st_next.wp = st_reg.wp + SAW'(1);
      end
      if (pop)
      begin
         st_next.rp = st_reg.rp + SAW'(1);
      end
      if (push & !pop)
      begin
         st_next.cnt = st_reg.cnt + (SAW+1)'(1);
      end
      else if (pop & !push)
      begin
         st_next.cnt = st_reg.cnt - (SAW+1)'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // storage needs no reset; only counted words are ever read
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[st_reg.wp] <= in_data;
      end
   end
endmodule // dcf_stage_fifo

// ----------------------------------------
// top level
// ----------------------------------------
module dcf_fifo_mailbox (
   // system clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // port one control
   input wire logic write_port_clock,
   input wire logic write_port_select_n,
   input wire logic write_port_enable,
   input wire logic side_one_write_select,
   input wire logic side_one_mailbox_select,
   // offset programming
   input wire logic offset_parallel_load,
   input wire logic offset_serial_enable_n,
   input wire logic offset_serial_data,
   // port one data bus
   input wire logic [dcf_pkg::DATA_W-1:0] side_one_data_in,
   output logic [dcf_pkg::DATA_W-1:0] side_one_data_out,
   output logic side_one_data_oe_n,
   // port one flags
   output logic input_ready_flag,
   output logic almost_full_n,
   output logic mail_to_one_flag_n,
   // port two control
   input wire logic read_port_clock,
   input wire logic read_port_select_n,
   input wire logic read_port_enable,
   input wire logic side_two_write_select,
   input wire logic side_two_mailbox_select,
   input wire logic retransmit_mode,
   input wire logic read_from_mark,
   // port two data bus
   input wire logic [dcf_pkg::DATA_W-1:0] side_two_data_in,
   output logic [dcf_pkg::DATA_W-1:0] side_two_data_out,
   output logic side_two_data_oe_n,
   // port two flags
   output logic output_ready_flag,
   output logic almost_empty_n,
   output logic mail_to_two_flag_n
);
   import dcf_pkg::*;

   typedef struct packed {
      dcf_pa_s pa1;
      dcf_pa_s pa2;
      dcf_pa_s pa3;
      logic pa_lvl;
      dcf_pb_s pb1;
      dcf_pb_s pb2;
      dcf_pb_s pb3;
      logic pb_lvl;
      logic [PW-1:0] wptr;
      logic [PW-1:0] wg;
      logic [PW-1:0] wg1;
      logic [PW-1:0] wg2;
      logic [PW-1:0] rptr;
      logic [PW-1:0] mark;
      logic rt_mode;
      logic [PW-1:0] pg;
      logic [PW-1:0] pg1;
      logic [PW-1:0] pg2;
      logic [DATA_W-1:0] out_word;
      logic or_flag;
      logic ae_n;
      logic ir;
      logic af_n;
      logic [DATA_W-1:0] mail1;
      logic [DATA_W-1:0] mail2;
      logic mail1_n;
      logic mail2_n;
      logic [AW-1:0] ofs_x;
      logic [AW-1:0] ofs_y;
      logic [DATA_W-1:0] a_dout;
      logic a_oe_n;
      logic [DATA_W-1:0] b_dout;
      logic b_oe_n;
   } dcf_top_s;

   dcf_top_s st_reg;
   dcf_top_s st_next;
   dcf_pa_s pa_pins;
   dcf_pb_s pb_pins;
   logic [DATA_W-1:0] mem [DEPTH];
   logic stage_in_valid;
   logic stage_in_ready;
   logic stage_out_valid;
   logic stage_out_ready;
   logic [DATA_W-1:0] stage_out_data;
   logic drain;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // pins gathered so every one passes the same three stages
   assign pa_pins = '{clk: write_port_clock, cs_n: write_port_select_n,
                      en: write_port_enable, wsel: side_one_write_select,
                      mb: side_one_mailbox_select, par_load: offset_parallel_load,
                      ser_en_n: offset_serial_enable_n, ser_data: offset_serial_data,
                      data: side_one_data_in};
   assign pb_pins = '{clk: read_port_clock, cs_n: read_port_select_n,
                      en: read_port_enable, wsel: side_two_write_select,
                      mb: side_two_mailbox_select, rtm: retransmit_mode,
                      rfm: read_from_mark, data: side_two_data_in};

   // array fill: stage drains while the array is not seen full
   assign drain = stage_out_valid & stage_out_ready;
   assign stage_out_ready = ((st_reg.wptr - gray2bin(st_reg.pg2)) != DEPTH_COUNT);

   dcf_stage_fifo #(
      .W(DATA_W),
      .D(STAGE_DEPTH)
   ) u_stage (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(stage_in_valid),
      .in_ready(stage_in_ready),
      .in_data(st_reg.pa3.data),
      .out_valid(stage_out_valid),
      .out_ready(stage_out_ready),
      .out_data(stage_out_data)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      logic a_edge;
      logic b_edge;
      logic a_wr;
      logic a_rd;
      logic b_wr;
      logic b_rd;
      logic fifo_rd;
      logic [PW-1:0] used;
      logic [PW-1:0] words;
      logic [PW-1:0] level;
      logic [2*AW-1:0] ser;
      a_edge = 1'b0;
      b_edge = 1'b0;
      used = st_reg.wptr - gray2bin(st_reg.pg2);
      words = gray2bin(st_reg.wg2) - st_reg.rptr;
      level = words + {{AW{1'b0}}, st_reg.or_flag};
      ser = {st_reg.ofs_y[AW-2:0], st_reg.ofs_x, st_reg.pa3.ser_data};
      st_next = st_reg;
      stage_in_valid = 1'b0;

      // three-stage sampling; an edge counts once stages two and three agree
      st_next.pa1 = pa_pins;
      st_next.pa2 = st_reg.pa1;
      st_next.pa3 = st_reg.pa2;
      st_next.pb1 = pb_pins;
      st_next.pb2 = st_reg.pb1;
      st_next.pb3 = st_reg.pb2;
      if (st_reg.pa2.clk == st_reg.pa3.clk)
      begin
         st_next.pa_lvl = st_reg.pa3.clk;
         a_edge = st_reg.pa3.clk & !st_reg.pa_lvl;
      end
      if (st_reg.pb2.clk == st_reg.pb3.clk)
      begin
         st_next.pb_lvl = st_reg.pb3.clk;
         b_edge = st_reg.pb3.clk & !st_reg.pb_lvl;
      end

      // qualified accesses on each port
      a_wr = a_edge & !st_reg.pa3.cs_n & st_reg.pa3.en & st_reg.pa3.wsel;
      a_rd = a_edge & !st_reg.pa3.cs_n & st_reg.pa3.en & !st_reg.pa3.wsel;
      b_wr = b_edge & !st_reg.pb3.cs_n & st_reg.pb3.en & !st_reg.pb3.wsel;
      b_rd = b_edge & !st_reg.pb3.cs_n & st_reg.pb3.en & st_reg.pb3.wsel;
      fifo_rd = b_rd & !st_reg.pb3.mb & st_reg.or_flag;

      // mailboxes: clear first so a set on the same cycle wins
      if (b_rd & st_reg.pb3.mb)
      begin
         st_next.mail1_n = 1'b1;
      end
      if (a_wr & st_reg.pa3.mb)
      begin
         st_next.mail1 = st_reg.pa3.data;
         st_next.mail1_n = 1'b0;
      end
      if (a_rd & st_reg.pa3.mb)
      begin
         st_next.mail2_n = 1'b1;
      end
      if (b_wr & st_reg.pb3.mb)
      begin
         st_next.mail2 = st_reg.pb3.data;
         st_next.mail2_n = 1'b0;
      end

      // offset programming: parallel word or one serial bit per edge
      if (a_wr & !st_reg.pa3.mb & st_reg.pa3.par_load)
      begin
         st_next.ofs_x = st_reg.pa3.data[PAR_X_LSB +: AW];
         st_next.ofs_y = st_reg.pa3.data[PAR_Y_LSB +: AW];
      end
      else if (a_edge & !st_reg.pa3.ser_en_n)
      begin
         {st_next.ofs_y, st_next.ofs_x} = ser;
      end

      // fifo write: refused while input ready is low
      if (a_wr & !st_reg.pa3.mb & !st_reg.pa3.par_load & st_reg.ir)
      begin
         stage_in_valid = 1'b1;
      end
      if (drain)
      begin
         st_next.wptr = st_reg.wptr + PTR_ONE;
      end
      st_next.wg = bin2gray(st_next.wptr);

      // read side protects the mark while retransmit is armed
      st_next.pg = bin2gray(st_reg.rt_mode ? st_reg.mark : st_reg.rptr);

      // port one flags: pointer passes two port-one stages
      if (a_edge)
      begin
         st_next.pg1 = st_reg.pg;
         st_next.pg2 = st_reg.pg1;
         st_next.ir = (used != DEPTH_COUNT) & stage_in_ready;
         st_next.af_n = !((DEPTH_COUNT - used) <= {1'b0, st_reg.ofs_y});
      end

      // port two: pointer passes two port-two stages, then loads the output
      if (b_edge)
      begin
         st_next.wg1 = st_reg.wg;
         st_next.wg2 = st_reg.wg1;
         st_next.ae_n = !(level <= {1'b0, st_reg.ofs_x});
         if (st_reg.rt_mode & st_reg.pb3.rfm)
         begin
            st_next.rptr = st_reg.mark;
            st_next.or_flag = 1'b0;
         end
         else if ((words != '0) & (!st_reg.or_flag | fifo_rd))
         begin
            st_next.out_word = mem[st_reg.rptr[AW-1:0]];
            st_next.rptr = st_reg.rptr + PTR_ONE;
            st_next.or_flag = 1'b1;
         end
         else if (fifo_rd)
         begin
            st_next.or_flag = 1'b0;
         end
         // mark is the word currently in the output register
         if (!st_reg.pb3.rtm)
         begin
            st_next.rt_mode = 1'b0;
         end
         else if (!st_reg.rt_mode & st_reg.or_flag)
         begin
            st_next.rt_mode = 1'b1;
            st_next.mark = st_reg.rptr - PTR_ONE;
         end
      end

      // bus drivers: released unless selected for a read
      st_next.a_oe_n = st_reg.pa3.cs_n | st_reg.pa3.wsel;
      st_next.a_dout = st_reg.mail2;
      st_next.b_oe_n = st_reg.pb3.cs_n | !st_reg.pb3.wsel;
      st_next.b_dout = st_reg.pb3.mb ? st_reg.mail1 : st_reg.out_word;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg <= '0;
         st_reg.mail1_n <= 1'b1;
         st_reg.mail2_n <= 1'b1;
         st_reg.af_n <= 1'b1;
         st_reg.a_oe_n <= 1'b1;
         st_reg.b_oe_n <= 1'b1;
         st_reg.ofs_x <= X_RESET;
         st_reg.ofs_y <= Y_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // array storage, written only from the stage
   always_ff @(posedge clk)
   begin
      if (drain)
      begin
         mem[st_reg.wptr[AW-1:0]] <= stage_out_data;
      end
   end

   // outputs straight from flip-flops
   assign side_one_data_out = st_reg.a_dout;
   assign side_one_data_oe_n = st_reg.a_oe_n;
   assign input_ready_flag = st_reg.ir;
   assign almost_full_n = st_reg.af_n;
   assign mail_to_one_flag_n = st_reg.mail2_n;
   assign side_two_data_out = st_reg.b_dout;
   assign side_two_data_oe_n = st_reg.b_oe_n;
   assign output_ready_flag = st_reg.or_flag;
   assign almost_empty_n = st_reg.ae_n;
   assign mail_to_two_flag_n = st_reg.mail1_n;
endmodule // dcf_fifo_mailbox
